// >>> iso_ep_cfg.svh
// constants for the host isochronous endpoint and transmit dma block
`ifndef ISO_EP_CFG_SVH
`define ISO_EP_CFG_SVH

`define XFER_ISOC        2'b01
`define TYPE_SPEED_HI    7
`define TYPE_SPEED_LO    6
`define TYPE_TRANSFER_TYPE_FIELD_HI     5
`define TYPE_TRANSFER_TYPE_FIELD_LO     4
`define RXC_DMA_EN       13
`define RXC_PING_DIS     12
`define RXC_DMA_MODE     11
`define RXC_REQ_PKT      5
`define RXC_DATA_ERR     3
`define RXC_PKT_RDY      0
`define TXC_FIFO_MODE    13
`define TXC_DMA_EN       12
`define TXC_DMA_MODE     10
`define TXC_PKT_RDY      0
`define FSZ_DOUBLE_BUF   4
`define NUM_EP           5
`define NUM_DMA_CH       4
`define DMA_BURST_BYTES  16'h0040
`define DESC_BYTES       16
`define DESC_ALIGN_MASK  32'h0000000f
`define FRAME_NS         125000
`define CLK_NS           10
`define FRAME_CYCLES     (`FRAME_NS / `CLK_NS)

`endif

// >>> iso_ep_pkg.sv
// types for the host isochronous endpoint and transmit dma block
`default_nettype none
package iso_ep_pkg;
    typedef struct packed {
        logic [6:0] target_address;
        logic [7:0] type_reg;
        logic [7:0] interval;
        logic [15:0] control;
        logic [1:0] auto_in;
        logic       double_buffer;
    } ep_cfg_t;

    typedef struct packed {
        logic [31:0] next_ptr;
        logic [31:0] buf_ptr;
        logic [15:0] offset;
        logic [15:0] length;
        logic        first;
        logic        last;
    } tx_desc_t;

    typedef enum logic [1:0] {
        st_idle  = 2'b00,
        st_token = 2'b01,
        st_data  = 2'b11,
        st_done  = 2'b10
    } xact_state_t;
endpackage
`default_nettype wire

// >>> usb_host_isoc_endpoint_dma.sv
// host isochronous in/out endpoint scheduling with transmit dma requests
`include "iso_ep_cfg.svh"
`default_nettype none
module usb_host_isoc_endpoint_dma (
    input  wire logic                 mclk_in,        // controller clock
    input  wire logic                 reset_in,       // sync reset, high
    input  wire logic [2:0]           ep_sel_in,      // endpoint of config
    input  wire logic                 cfg_wr_in,      // rx config write
    input  wire iso_ep_pkg::ep_cfg_t  rx_cfg_in,      // rx endpoint config
    input  wire logic                 tx_cfg_wr_in,   // tx config write
    input  wire iso_ep_pkg::ep_cfg_t  tx_cfg_in,      // tx endpoint config
    input  wire logic                 rx_ready_clr_in, // sw cleared rx ready
    input  wire logic                 tx_load_in,     // sw loaded a tx packet
    input  wire logic                 rx_pkt_in,      // packet from bus
    input  wire logic                 rx_err_in,      // crc or stuff error
    input  wire logic                 tx_sent_in,     // out packet sent
    input  wire logic                 tx_fail_in,     // out packet error
    input  wire iso_ep_pkg::tx_desc_t desc_in,        // descriptor fetched
    input  wire logic                 desc_valid_in,  // descriptor strobe
    output logic                      sof_pulse_out,  // frame start pulse
    output logic                      in_token_out,   // send in token
    output logic                      out_token_out,  // send out token
    output logic [6:0]                token_addr_out, // function address
    output logic [7:0]                token_type_out, // speed/type/endpoint
    output logic                      ping_en_out,    // high speed ping flow
    output logic [4:0]                rx_ready_out,   // rx packet ready
    output logic [4:0]                rx_err_out,     // rx data error
    output logic [4:0]                rx_irq_out,     // rx endpoint event
    output logic [4:0]                tx_irq_out,     // tx endpoint event
    output logic [3:0]                rx_dma_req_out, // rx dma per channel
    output logic [3:0]                tx_dma_req_out, // tx dma per channel
    output logic [15:0]               burst_len_out,  // dma burst bytes
    output logic [31:0]               burst_addr_out, // dma burst address
    output logic                      desc_bad_out,   // descriptor fault
    output logic                      queue_end_out   // last descriptor
);
    import iso_ep_pkg::*;

    localparam int NEP = `NUM_EP;
    localparam logic [15:0] FRAME_CNT = 16'(`FRAME_CYCLES - 1);

    ep_cfg_t        rx_cfg [NEP];
    ep_cfg_t        tx_cfg [NEP];
    logic [15:0]    frame_cnt;
    logic [7:0]     rx_ivl [NEP];
    logic [7:0]     tx_ivl [NEP];
    logic [4:0]     rx_pend;
    logic [4:0]     rx_busy;
    logic [1:0]     tx_fill [NEP];
    logic [2:0]     cur_ep;
    xact_state_t    state;
    xact_state_t    next_state;
    logic           cur_is_tx;

    wire frame_tick = (frame_cnt == FRAME_CNT);

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            frame_cnt     <= 16'h0000;
            sof_pulse_out <= 1'b0;
        end else begin
            frame_cnt     <= frame_tick ? 16'h0000 : frame_cnt + 16'h0001;
            sof_pulse_out <= frame_tick;
        end
    end

    // per endpoint target address and type storage, ep0..ep4
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            for (int i = 0; i < NEP; i++) begin
                rx_cfg[i] <= '0;
                tx_cfg[i] <= '0;
            end
        end else begin
            if (cfg_wr_in && ep_sel_in < 3'(NEP))
                rx_cfg[ep_sel_in] <= rx_cfg_in;
            if (tx_cfg_wr_in && ep_sel_in < 3'(NEP))
                tx_cfg[ep_sel_in] <= tx_cfg_in;
        end
    end

    // isochronous when the type field reads 01
    function automatic logic is_iso(input ep_cfg_t c);
        return c.type_reg[`TYPE_TRANSFER_TYPE_FIELD_HI:`TYPE_TRANSFER_TYPE_FIELD_LO] == `XFER_ISOC;
    endfunction

    // tx fifo capacity: two packets with double buffering, else one
    function automatic logic [1:0] tx_cap(input ep_cfg_t c);
        return c.double_buffer ? 2'd2 : 2'd1;
    endfunction

    // pick the lowest endpoint whose slot is due and has work
    logic [2:0] pick_ep;
    logic       pick_tx;
    logic       pick_ok;
    always_comb begin
        pick_ep = 3'd0;
        pick_tx = 1'b0;
        pick_ok = 1'b0;
        for (int i = NEP - 1; i >= 0; i--) begin
            // one per interval, skip when idle
            if (is_iso(tx_cfg[i]) && tx_ivl[i] == 8'h00 &&
                tx_fill[i] != 2'd0 &&
                // fifo mode bit selects tx use
                tx_cfg[i].control[`TXC_FIFO_MODE]) begin
                pick_ep = 3'(i);
                pick_tx = 1'b1;
                pick_ok = 1'b1;
            end
            if (is_iso(rx_cfg[i]) && rx_ivl[i] == 8'h00 && rx_pend[i]) begin
                pick_ep = 3'(i);
                pick_tx = 1'b0;
                pick_ok = 1'b1;
            end
        end
    end

    always_comb begin
        case (state)
            st_idle:  next_state = pick_ok ? st_token : st_idle;
            st_token: next_state = st_data;
            st_data: begin
                if (cur_is_tx)
                    next_state = (tx_sent_in || tx_fail_in) ? st_done : st_data;
                else
                    next_state = rx_pkt_in ? st_done : st_data;
            end
            st_done:  next_state = st_idle;
            default:  next_state = st_idle;
        endcase
    end

    wire ep_cur_rx_auto = rx_cfg[cur_ep].control[`RXC_DMA_EN] &&
                          (rx_cfg[cur_ep].auto_in == 2'b01 ||
                           rx_cfg[cur_ep].auto_in == 2'b11);
    wire take = (state == st_idle) && pick_ok;
    wire rx_got = (state == st_data) && !cur_is_tx && rx_pkt_in;
    wire tx_end = (state == st_data) && cur_is_tx &&
                  (tx_sent_in || tx_fail_in);

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            state          <= st_idle;
            cur_ep         <= 3'd0;
            cur_is_tx      <= 1'b0;
            in_token_out   <= 1'b0;
            out_token_out  <= 1'b0;
            token_addr_out <= 7'h00;
            token_type_out <= 8'h00;
            ping_en_out    <= 1'b0;
        end else begin
            state         <= next_state;
            in_token_out  <= take && !pick_tx;
            out_token_out <= take && pick_tx;
            if (take) begin
                cur_ep    <= pick_ep;
                cur_is_tx <= pick_tx;
                // speed and target endpoint go with the token
                token_addr_out <= pick_tx ? tx_cfg[pick_ep].target_address
                                          : rx_cfg[pick_ep].target_address;
                token_type_out <= pick_tx ? tx_cfg[pick_ep].type_reg
                                          : rx_cfg[pick_ep].type_reg;
                // ping only at high speed with the bit clear
                ping_en_out <= !pick_tx &&
                    !rx_cfg[pick_ep].control[`RXC_PING_DIS] &&
                    rx_cfg[pick_ep].type_reg[`TYPE_SPEED_HI:`TYPE_SPEED_LO]
                        == 2'b01;
            end
        end
    end

    // per endpoint interval counters, pending requests and fifo fill
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            rx_pend      <= 5'h00;
            rx_busy      <= 5'h00;
            rx_ready_out <= 5'h00;
            rx_err_out   <= 5'h00;
            rx_irq_out   <= 5'h00;
            tx_irq_out   <= 5'h00;
            for (int i = 0; i < NEP; i++) begin
                rx_ivl[i]  <= 8'h00;
                tx_ivl[i]  <= 8'h00;
                tx_fill[i] <= 2'd0;
            end
        end else begin
            rx_irq_out <= 5'h00;
            tx_irq_out <= 5'h00;
            for (int i = 0; i < NEP; i++) begin
                // reload interval each used slot, count frames
                if (take && pick_ep == 3'(i) && !pick_tx)
                    rx_ivl[i] <= rx_cfg[i].interval;
                else if (frame_tick && rx_ivl[i] != 8'h00)
                    rx_ivl[i] <= rx_ivl[i] - 8'h01;
                if (take && pick_ep == 3'(i) && pick_tx)
                    tx_ivl[i] <= tx_cfg[i].interval;
                else if (frame_tick && tx_ivl[i] != 8'h00)
                    tx_ivl[i] <= tx_ivl[i] - 8'h01;

                // request bit arms an in token
                if (cfg_wr_in && ep_sel_in == 3'(i) &&
                    rx_cfg_in.control[`RXC_REQ_PKT])
                    rx_pend[i] <= 1'b1;
                else if (take && pick_ep == 3'(i) && !pick_tx)
                    rx_pend[i] <= 1'b0;
                // auto request once ready is cleared
                else if (rx_ready_clr_in && ep_sel_in == 3'(i) &&
                         rx_busy[i])
                    rx_pend[i] <= 1'b1;

                if (rx_got && cur_ep == 3'(i)) begin
                    // ready flag set wins over clear
                    rx_ready_out[i] <= 1'b1;
                    rx_busy[i]      <= ep_cur_rx_auto;
                    rx_err_out[i]   <= rx_err_in;
                    // event pulse, not when dma owns it unless the packet errored
                    rx_irq_out[i] <= !rx_cfg[i].control[`RXC_DMA_EN] ||
                                     rx_err_in;
                end else if (rx_ready_clr_in && ep_sel_in == 3'(i)) begin
                    rx_ready_out[i] <= 1'b0;
                    rx_err_out[i]   <= 1'b0;
                    rx_busy[i]      <= 1'b0;
                end

                // fill counts loaded packets up to capacity
                if (tx_end && cur_ep == 3'(i) && !(tx_load_in &&
                    ep_sel_in == 3'(i)))
                    tx_fill[i] <= tx_fill[i] - 2'd1;
                else if (!(tx_end && cur_ep == 3'(i)) && tx_load_in &&
                         ep_sel_in == 3'(i) && tx_fill[i] < tx_cap(tx_cfg[i]))
                    tx_fill[i] <= tx_fill[i] + 2'd1;

                // dma mode hides per packet events, errors stay
                if (tx_end && cur_ep == 3'(i))
                    tx_irq_out[i] <= tx_fail_in ||
                        !(tx_cfg[i].control[`TXC_DMA_EN] &&
                          tx_cfg[i].control[`TXC_DMA_MODE]);
            end
        end
    end

    // channel k drives endpoint k+1, endpoint 0 has none
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            rx_dma_req_out <= 4'h0;
            tx_dma_req_out <= 4'h0;
        end else begin
            for (int k = 0; k < `NUM_DMA_CH; k++) begin
                // rx dma request while a packet waits
                rx_dma_req_out[k] <= rx_cfg[k+1].control[`RXC_DMA_EN] &&
                                     rx_ready_out[k+1];
                // tx dma request while fifo has room
                tx_dma_req_out[k] <= tx_cfg[k+1].control[`TXC_DMA_EN] &&
                                     tx_fill[k+1] < tx_cap(tx_cfg[k+1]);
            end
        end
    end

    // descriptor check and first burst; offset only counts on a first buf
    // offset and length from word 2
    wire [15:0] desc_off = desc_in.first ? desc_in.offset : 16'h0000;
    wire [15:0] desc_left = desc_in.length - desc_off;
    // 16 byte alignment of the next pointer
    wire desc_misalign = (desc_in.next_ptr & `DESC_ALIGN_MASK) != 32'h0;
    // first/last flags; offset illegal off a first buffer
    wire desc_off_bad = (!desc_in.first && desc_in.offset != 16'h0000) ||
                        (desc_in.offset >= desc_in.length);

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            burst_len_out  <= 16'h0000;
            burst_addr_out <= 32'h00000000;
            desc_bad_out   <= 1'b0;
            queue_end_out  <= 1'b0;
        end else if (desc_valid_in) begin
            // capped burst at buffer pointer plus first-buffer offset
            burst_len_out  <= (desc_left > `DMA_BURST_BYTES) ?
                              `DMA_BURST_BYTES : desc_left;
            burst_addr_out <= desc_in.buf_ptr + {16'h0000, desc_off};
            desc_bad_out   <= desc_misalign || desc_off_bad;
            // zero next pointer marks the queue end
            queue_end_out  <= desc_in.next_ptr == 32'h0;
        end
    end
endmodule
`default_nettype wire

// >>> usb_host_isoc_endpoint_dma_props.sv
// port-level checks for the host isochronous endpoint block
`include "iso_ep_cfg.svh"
`default_nettype none
module usb_host_isoc_endpoint_dma_props (
    input wire logic                 mclk_in,         // clock
    input wire logic                 reset_in,        // sync reset
    input wire logic                 rx_pkt_in,       // packet from bus
    input wire logic                 rx_err_in,       // packet error
    input wire logic                 rx_ready_clr_in, // ready cleared
    input wire iso_ep_pkg::tx_desc_t desc_in,         // descriptor
    input wire logic                 desc_valid_in,   // descriptor strobe
    input wire logic                 sof_pulse_out,   // frame pulse
    input wire logic                 in_token_out,    // in token
    input wire logic                 out_token_out,   // out token
    input wire logic [7:0]           token_type_out,  // token type
    input wire logic [4:0]           rx_ready_out,    // rx ready flags
    input wire logic [4:0]           rx_err_out,      // rx error flags
    input wire logic [15:0]          burst_len_out,   // burst bytes
    input wire logic                 desc_bad_out,    // descriptor fault
    input wire logic                 queue_end_out    // last descriptor
);
    import iso_ep_pkg::*;
    logic [13:0] since_sof;
    logic        seen_sof;
    logic        in_wait;
    wire logic   tok = in_token_out | out_token_out;
    // zero length is never legal, so offset >= length is always a fault
    wire logic   fault = (|desc_in.next_ptr[3:0])
        | ((desc_in.offset != 16'h0000) & ~desc_in.first)
        | (desc_in.offset >= desc_in.length);
    always_ff @(posedge mclk_in) begin
        if (reset_in | sof_pulse_out) begin
            since_sof <= 14'h0000;
        end else begin
            since_sof <= since_sof + 14'h0001;
        end
        if (reset_in) begin
            seen_sof <= 1'b0;
            in_wait  <= 1'b0;
        end else begin
            seen_sof <= seen_sof | sof_pulse_out;
            in_wait  <= in_token_out | (in_wait & ~rx_pkt_in);
        end
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    a_sof_period: assert property (
        sof_pulse_out && seen_sof |-> since_sof == 14'(`FRAME_CYCLES - 1))
        else $error("frame pulse spacing wrong");
    a_ready_sets: assert property (
        in_wait && rx_pkt_in |=> rx_ready_out != 5'h00)
        else $error("no ready flag after packet");
    a_err_stored: assert property (
        in_wait && rx_pkt_in && rx_err_in |=> |(rx_err_out & rx_ready_out))
        else $error("errored packet not kept");
    a_ready_holds: assert property (
        |($past(rx_ready_out) & ~rx_ready_out) |-> $past(rx_ready_clr_in))
        else $error("ready flag dropped on its own");
    a_token_gap: assert property (
        tok |=> !tok [*3])
        else $error("transactions too close");
    a_token_iso: assert property (
        tok |-> token_type_out[5:4] == `XFER_ISOC)
        else $error("token for non isochronous endpoint");
    a_burst_cap: assert property (
        burst_len_out <= `DMA_BURST_BYTES)
        else $error("burst longer than cap");
    a_queue_end: assert property (
        desc_valid_in |=> queue_end_out == ($past(desc_in.next_ptr) == 0))
        else $error("queue end flag wrong");
    a_desc_fault: assert property (
        desc_valid_in |=> desc_bad_out == $past(fault))
        else $error("descriptor fault flag wrong");
    c_sof: cover property (sof_pulse_out && seen_sof);
    c_err: cover property (in_wait && rx_err_in);
    c_out: cover property (out_token_out);
    c_bad: cover property (desc_valid_in ##1 desc_bad_out);
endmodule
`default_nettype wire

// >>> usb_peer_model.sv
// behavioural usb peripheral answering the host block's tokens
`default_nettype none
module usb_peer_model (
    input  wire logic mclk_in,    // controller clock
    input  wire logic in_tok_in,  // in token seen
    input  wire logic out_tok_in, // out token seen
    input  wire logic slow_in,    // long turnaround
    input  wire logic bad_in,     // corrupt or failed transfer
    output var  logic pkt_out,    // data packet in
    output var  logic err_out,    // crc or stuff error
    output var  logic sent_out,   // out packet taken
    output var  logic fail_out    // out packet lost
);
    logic [2:0] wait_cnt = 3'd0;
    logic       is_out = 1'b0;
    initial {pkt_out, err_out, sent_out, fail_out} = 4'h0;
    // one packet or status per token, nothing sent unprompted
    // answer each token after a short or long turnaround
    always @(posedge mclk_in) begin
        {pkt_out, err_out, sent_out, fail_out} <= 4'h0;
        if (in_tok_in | out_tok_in) begin
            wait_cnt <= slow_in ? 3'd4 : 3'd1;
            is_out   <= out_tok_in;
        end else if (wait_cnt != 3'd0) begin
            wait_cnt <= wait_cnt - 3'd1;
            // a corrupt packet still arrives whole
            if (wait_cnt == 3'd1) begin
                {pkt_out, err_out} <= is_out ? 2'b00 : {1'b1, bad_in};
                {sent_out, fail_out} <= is_out ? {~bad_in, bad_in} : 2'b00;
            end
        end
    end
endmodule
`default_nettype wire

// >>> test_usb_host_isoc_endpoint_dma.sv
// self-checking bench for the host isochronous endpoint block
`include "iso_ep_cfg.svh"
`default_nettype none
module test_usb_host_isoc_endpoint_dma;
    timeunit 1ns;
    timeprecision 1ps;
    import iso_ep_pkg::*;
    typedef struct packed {
        logic [2:0]  ep;
        logic        tx;
        logic [15:0] ctl;
        logic        hs;
        logic        bad;
        logic        irq;
        logic        ping;
    } row_t;
    // rx rows keep the dma mode bit 11 clear
    row_t rows [9] = '{'{0, 0, 16'h0020, 0, 0, 1, 0},
        '{1, 0, 16'h2020, 0, 0, 0, 0}, '{2, 0, 16'h0020, 0, 1, 1, 0},
        '{3, 0, 16'h1020, 1, 0, 1, 0}, '{4, 0, 16'h0020, 1, 0, 1, 1},
        '{1, 1, 16'h2000, 0, 0, 1, 0}, '{2, 1, 16'h3400, 0, 0, 0, 0},
        '{3, 1, 16'h3400, 0, 1, 1, 0}, '{4, 1, 16'h3000, 0, 0, 1, 0}};
    tx_desc_t descs [5] = '{'{32'h100, 32'h1000, 16'h0, 16'h20, 1'b1, 1'b1},
        '{32'h0, 32'h2000, 16'h4, 16'h100, 1'b1, 1'b0},
        '{32'h108, 32'h3000, 16'h0, 16'h10, 1'b0, 1'b1},
        '{32'h200, 32'h4000, 16'h2, 16'h10, 1'b0, 1'b0},
        '{32'h200, 32'h5000, 16'h20, 16'h20, 1'b1, 1'b1}};
    logic [17:0] dexp [5] = '{18'h00020, 18'h10040, 18'h20000, 18'h20000,
        18'h20000};
    logic mclk_in = 0, reset_in = 1, cfg_wr_in = 0, tx_cfg_wr_in = 0;
    logic rx_ready_clr_in = 0, tx_load_in = 0, desc_valid_in = 0;
    logic slow = 0, bad = 0, desc_bad_out, queue_end_out, sof_pulse_out;
    logic in_token_out, out_token_out, ping_en_out;
    logic [2:0]  ep_sel_in = 0;
    ep_cfg_t     rx_cfg_in = '0, tx_cfg_in = '0;
    tx_desc_t    desc_in = '0;
    wire logic   rx_pkt_in, rx_err_in, tx_sent_in, tx_fail_in;
    logic [6:0]  token_addr_out;
    logic [7:0]  token_type_out;
    logic [4:0]  rx_ready_out, rx_err_out, rx_irq_out, tx_irq_out, irq_seen;
    logic [3:0]  rx_dma_req_out, tx_dma_req_out, dq;
    logic [15:0] burst_len_out;
    logic [31:0] burst_addr_out;
    row_t        r;
    int          mismatches = 0, n_compared = 0, cycles = 0;
    usb_host_isoc_endpoint_dma u_usb_host_isoc_endpoint_dma (.mclk_in,
        .reset_in, .ep_sel_in, .cfg_wr_in, .rx_cfg_in, .tx_cfg_wr_in,
        .tx_cfg_in, .rx_ready_clr_in, .tx_load_in, .rx_pkt_in, .rx_err_in,
        .tx_sent_in, .tx_fail_in, .desc_in, .desc_valid_in, .sof_pulse_out,
        .in_token_out, .out_token_out, .token_addr_out, .token_type_out,
        .ping_en_out, .rx_ready_out, .rx_err_out, .rx_irq_out, .tx_irq_out,
        .rx_dma_req_out, .tx_dma_req_out, .burst_len_out, .burst_addr_out,
        .desc_bad_out, .queue_end_out);
    usb_peer_model u_usb_peer_model (.mclk_in, .in_tok_in(in_token_out),
        .out_tok_in(out_token_out), .slow_in(slow), .bad_in(bad),
        .pkt_out(rx_pkt_in), .err_out(rx_err_in), .sent_out(tx_sent_in),
        .fail_out(tx_fail_in));
    always #5 mclk_in = ~mclk_in;
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // three frames of traffic fit well inside this ceiling
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic ep_cfg_t mk(input logic [2:0] ep,
        input logic [15:0] ctl, input logic hs, input logic [2:0] ext);
        return {7'h20 + 7'(ep), hs ? 2'b01 : 2'b10, `XFER_ISOC,
            4'(ep) + 4'd3, 8'h01, ctl, ext};
    endfunction
    // k picks the strobe: cfg, tx cfg, ready clear, load, descriptor
    task automatic strobe(input logic [2:0] ep, input int k, input ep_cfg_t c);
        @(posedge mclk_in);
        ep_sel_in <= ep;
        rx_cfg_in <= c;
        tx_cfg_in <= c;
        {desc_valid_in, tx_load_in, rx_ready_clr_in, tx_cfg_wr_in,
            cfg_wr_in} <= 5'b00001 << k;
        @(posedge mclk_in);
        {desc_valid_in, tx_load_in, rx_ready_clr_in, tx_cfg_wr_in,
            cfg_wr_in} <= 5'b00000;
        #1;
    endtask
    task automatic xact(input logic out, input ep_cfg_t c);
        int i;
        for (i = 0; i < 40; i++) begin
            if ((out ? out_token_out : in_token_out) === 1'b1) break;
            @(posedge mclk_in);
            #1;
        end
        chk(i < 40, 1);
        chk(token_addr_out, c.target_address);
        chk(token_type_out, c.type_reg);
        for (i = 0; i < 12 && !(rx_pkt_in | tx_sent_in | tx_fail_in); i++) begin
            @(posedge mclk_in);
            #1;
        end
        @(posedge mclk_in);
        #1;
        irq_seen = out ? tx_irq_out : rx_irq_out;
        // dma requests follow the flags one clock later
        @(posedge mclk_in);
        #1;
    endtask
    task automatic quiet();
        int n;
        n = 0;
        while (sof_pulse_out !== 1'b1) begin
            @(posedge mclk_in);
            #1;
            n += in_token_out | out_token_out;
        end
        chk(n, 0);
    endtask
    initial begin
        repeat (8) @(posedge mclk_in);
        reset_in <= 1'b0;
        foreach (rows[i]) begin
            r = rows[i];
            slow <= i[0];
            bad <= r.bad;
            strobe(r.ep, r.tx, mk(r.ep, r.ctl, r.hs, 3'b000));
            if (r.tx) strobe(r.ep, 3, '0);
            xact(r.tx, mk(r.ep, r.ctl, r.hs, 3'b000));
            chk(irq_seen[r.ep], r.irq);
            chk(ping_en_out, r.ping);
            dq = r.tx ? tx_dma_req_out : rx_dma_req_out;
            if (r.ep != 0)
                chk(dq[r.ep - 3'd1], r.ctl[12 + !r.tx]);
            if (!r.tx) begin
                chk(rx_ready_out[r.ep], 1);
                chk(rx_err_out[r.ep], r.bad);
                strobe(r.ep, 2, '0);
                chk(rx_ready_out[r.ep], 0);
            end
        end
        bad <= 1'b0;
        strobe(0, 0, mk(0, 16'h0020, 0, 3'b000));
        strobe(1, 0, mk(1, 16'h2020, 0, 3'b110));
        strobe(4, 1, mk(4, 16'h3000, 0, 3'b001));
        chk(tx_dma_req_out[3], 1);
        strobe(4, 3, '0);
        @(posedge mclk_in);
        #1;
        chk(tx_dma_req_out[3], 1);
        repeat (2) strobe(4, 3, '0);
        chk(tx_dma_req_out[3], 0);
        quiet();
        xact(0, mk(0, 16'h0020, 0, 3'b000));
        xact(0, mk(1, 16'h2020, 0, 3'b110));
        xact(1, mk(4, 16'h3000, 0, 3'b001));
        chk(tx_dma_req_out[3], 1);
        strobe(0, 2, '0);
        strobe(1, 2, '0);
        quiet();
        xact(0, mk(1, 16'h2020, 0, 3'b110));
        xact(1, mk(4, 16'h3000, 0, 3'b001));
        foreach (descs[i]) begin
            @(posedge mclk_in);
            desc_in <= descs[i];
            strobe(0, 4, '0);
            chk({desc_bad_out, queue_end_out}, dexp[i][17:16]);
            if (!dexp[i][17]) chk(burst_len_out, dexp[i][15:0]);
            if (!dexp[i][17]) chk(burst_addr_out, descs[i].buf_ptr + descs[i].offset);
        end
        @(posedge mclk_in);
        reset_in <= 1'b1;
        repeat (8) @(posedge mclk_in);
        #1;
        chk({rx_ready_out, rx_err_out, tx_dma_req_out, queue_end_out}, 0);
        test_done();
    end
endmodule
bind usb_host_isoc_endpoint_dma usb_host_isoc_endpoint_dma_props u_props (
    .mclk_in, .reset_in, .rx_pkt_in, .rx_err_in, .rx_ready_clr_in, .desc_in,
    .desc_valid_in, .sof_pulse_out, .in_token_out, .out_token_out,
    .token_type_out, .rx_ready_out, .rx_err_out, .burst_len_out,
    .desc_bad_out, .queue_end_out);
`default_nettype wire
